// File: dv/tobs_chk_checker.sv
// checker for the trace observation port outputs
// assumes binding onto tobs_port, one clock domain
`timescale 1ns/100ps
module tobs_chk
(
	// clock and resets
	input wire sys_clk,
	input wire rst,
	input wire sys_reset_n,
	input wire debug_reset_n,
	// core side
	input wire bus_clock_enable,
	input wire vector_strap_in,
	input wire core_isa_alt,
	input wire [1:0] core_access_size,
	input wire [31:0] core_read_data,
	input wire [31:0] core_write_data,
	input wire core_exec_valid,
	input wire core_exec_flush,
	input wire core_write,
	input wire core_wait,
	// trace side
	input wire trace_port_enable_in,
	input wire trace_isa_state,
	input wire trace_vector_base_high,
	input wire [1:0] trace_access_size,
	input wire [31:0] trace_read_data,
	input wire [31:0] trace_write_data,
	input wire trace_instr_valid,
	input wire trace_write_not_read,
	input wire trace_wait_indicator
);
	wire ok = !rst && sys_reset_n && debug_reset_n;
	wire ld = ok && bus_clock_enable && trace_port_enable_in;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!ok);
	property p_isa; ld |=> trace_isa_state == $past(core_isa_alt); endproperty
	a_isa: assert property (p_isa) else $error("isa");
	property p_vec; $rose(ok) |=> trace_vector_base_high == $past(vector_strap_in); endproperty
	a_vec: assert property (p_vec) else $error("vec");
	property p_dat; ld |=> {trace_access_size, trace_read_data, trace_write_data}
		== $past({core_access_size, core_read_data, core_write_data}); endproperty
	a_dat: assert property (p_dat) else $error("dat");
	property p_iv; ld |=> trace_instr_valid == $past(core_exec_valid && !core_exec_flush); endproperty
	a_iv: assert property (p_iv) else $error("iv");
	property p_wnr; ld |=> trace_write_not_read == $past(core_write); endproperty
	a_wnr: assert property (p_wnr) else $error("wnr");
	property p_wait; ok |=> trace_wait_indicator == $past(core_wait); endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_hold; !bus_clock_enable |=> $stable({trace_isa_state, trace_read_data}); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_dbg; disable iff (1'h0) !debug_reset_n |-> trace_read_data == 32'h0; endproperty
	a_dbg: assert property (p_dbg) else $error("dbg");
endmodule // tobs_chk
bind tobs_port tobs_chk u_tobs_chk(.*);

// File: dv/tobs_port_bench.sv
// self-checking bench for the trace observation port
// assumes the macrocell model and checker beside it
`timescale 1ns/100ps
`include "tobs_consts.vh"
`define CK(a,b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD %0t mismatch", $time); end end
module tobs_port_bench;
	logic sys_clk = 0, rst = 1, sys_reset_n = 1, debug_reset_n = 1, bus_clock_enable = 1;
	logic vector_strap_in = 0, core_isa_alt = 0, core_exec_valid = 0, core_exec_flush = 0;
	logic core_write = 0, core_wait = 0, pen_req = 1, reg_write = 0, reg_read = 0;
	logic [1:0] core_access_size = 0, trace_access_size;
	logic [31:0] core_read_data = 0, core_write_data = 0, reg_wdata = 0;
	logic [31:0] trace_read_data, trace_write_data, reg_rdata;
	logic [7:0] reg_addr = 0;
	logic trace_port_enable_in, trace_isa_state, trace_endian_out, endian_out;
	logic trace_vector_base_high, trace_instr_valid, trace_write_not_read, trace_wait_indicator;
	int n_errors = 0, samples_checked = 0;
	always #12.5 sys_clk = ~sys_clk;
	tobs_port u_tobs_port(.*);
	tobs_tmc u_tobs_tmc(.*);
	task wr(input [7:0] a, input [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge sys_clk);
		reg_write <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge sys_clk);
		reg_read <= 0;
		#1 `CK(reg_rdata, e)
	endtask
	task t_cfg;
		wr(`TOBS_CTRL_ADDR, 32'h3);
		#1 `CK({trace_endian_out, endian_out, trace_vector_base_high}, 3'h7)
		rd(8'h10, 32'h0);
		rd(`TOBS_CTRL_ADDR, 32'h3);
		wr(`TOBS_CTRL_ADDR, 32'h0);
		#1 `CK({trace_endian_out, endian_out, trace_vector_base_high}, 3'h0)
	endtask
	task t_trace;
		@(posedge sys_clk);
		{core_isa_alt, core_exec_valid, core_write, core_wait} <= 4'hF;
		core_access_size <= 2'h2;
		core_read_data <= 32'hA5A50001;
		core_write_data <= 32'h5A5A0002;
		@(posedge sys_clk);
		#1 `CK({trace_isa_state, trace_instr_valid, trace_write_not_read}, 3'h7)
		`CK({trace_access_size, trace_read_data, trace_write_data}, 66'h2A5A500015A5A0002)
		rd(`TOBS_STATUS_ADDR, 32'h5F);
		rd(`TOBS_CAPT_ADDR, 32'h5A5A0002);
		@(posedge sys_clk);
		bus_clock_enable <= 0;
		core_exec_flush <= 1;
		core_read_data <= 32'h0;
		core_wait <= 0;
		@(posedge sys_clk);
		#1 `CK({trace_instr_valid, trace_read_data, trace_wait_indicator}, 34'h34B4A0002)
		@(posedge sys_clk);
		bus_clock_enable <= 1;
		@(posedge sys_clk);
		#1 `CK(trace_instr_valid, 1'h0)
	endtask
	task t_gate;
		@(posedge sys_clk);
		pen_req <= 0;
		wr(`TOBS_CTRL_ADDR, 32'h4);
		core_isa_alt <= 0;
		repeat (2) @(posedge sys_clk);
		#1 `CK(trace_isa_state, 1'h1)
		@(posedge sys_clk);
		pen_req <= 1;
		repeat (2) @(posedge sys_clk);
		#1 `CK(trace_isa_state, 1'h0)
	endtask
	task t_rst;
		@(posedge sys_clk);
		vector_strap_in <= 1;
		sys_reset_n <= 0;
		@(posedge sys_clk);
		#1 `CK({trace_instr_valid, trace_write_data, reg_rdata}, 65'h0)
		@(posedge sys_clk);
		sys_reset_n <= 1;
		repeat (2) @(posedge sys_clk);
		#1 `CK(trace_vector_base_high, 1'h1)
		@(posedge sys_clk);
		debug_reset_n <= 0;
		#1 `CK({trace_vector_base_high, trace_read_data}, 33'h0)
		@(posedge sys_clk);
		debug_reset_n <= 1;
	endtask
	task end_sim;
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		t_cfg;
		t_trace;
		t_gate;
		t_rst;
		end_sim;
	end
endmodule // tobs_port_bench

// File: dv/tobs_tmc.sv
// trace macrocell model: drives its enable toward the port
// assumes a request level from the bench
`timescale 1ns/100ps
module tobs_tmc
(
	// clock
	input wire sys_clk,
	// request and port side
	input wire pen_req,
	output reg trace_port_enable_in
);
	// rising edge only, wait flag never used as enable
	always @(posedge sys_clk)
	begin
		trace_port_enable_in <= pen_req;
	end
endmodule // tobs_tmc

// File: hdl/tobs_port.v
// trace observation port: exports core execution state to a trace macrocell
// assumes all inputs but debug_reset_n synchronous to sys_clk; bus_clock_enable from the system
//
// Summary of operation
// - isa state high for compact set
// - both endian outputs high when big-endian
// - vector base high means vectors at top
// - strap loads high-vector bit leaving reset
// - two-bit access size toward trace unit
// - read and write data on separate outputs
// - instr valid only when executing and unflushed
// - direction high for write, low read
// - wait indicator flags wait, not clock enable
// - everything on rising sys_clk edge
// - active-low system reset resets logic
// - debug reset is asynchronous, active low
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "tobs_consts.vh"

module tobs_port
(
	// clock and resets
	input wire sys_clk,
	input wire rst,
	input wire sys_reset_n,
	input wire debug_reset_n,
	// system timing and straps
	input wire bus_clock_enable,
	input wire vector_strap_in,
	// core execution state
	input wire core_isa_alt,
	input wire [`TOBS_SIZE_W-1:0] core_access_size,
	input wire [`TOBS_WORD_W-1:0] core_read_data,
	input wire [`TOBS_WORD_W-1:0] core_write_data,
	input wire core_exec_valid,
	input wire core_exec_flush,
	input wire core_write,
	input wire core_wait,
	// trace macrocell side
	input wire trace_port_enable_in,
	output wire trace_isa_state,
	output wire trace_endian_out,
	output wire endian_out,
	output wire trace_vector_base_high,
	output wire [`TOBS_SIZE_W-1:0] trace_access_size,
	output wire [`TOBS_WORD_W-1:0] trace_read_data,
	output wire [`TOBS_WORD_W-1:0] trace_write_data,
	output wire trace_instr_valid,
	output wire trace_write_not_read,
	output reg trace_wait_indicator,
	// register port
	input wire [`TOBS_ADDR_W-1:0] reg_addr,
	input wire [`TOBS_DATA_W-1:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [`TOBS_DATA_W-1:0] reg_rdata
);

// ****************************************
// reset combination
// ****************************************
// either source resets; both are taken on the clock edge
wire sys_rst;
assign sys_rst = rst | ~sys_reset_n;

// ****************************************
// register address decode
// ****************************************
wire ctrl_sel;
wire stat_sel;
wire capt_sel;
wire ctrl_wr;
wire capt_wr;

assign ctrl_sel = (reg_addr == `TOBS_CTRL_ADDR);
assign stat_sel = (reg_addr == `TOBS_STATUS_ADDR);
assign capt_sel = (reg_addr == `TOBS_CAPT_ADDR);
assign ctrl_wr = reg_write & ctrl_sel;
assign capt_wr = reg_write & capt_sel;

// ****************************************
// control register next value
// ****************************************
reg [`TOBS_CTRL_W-1:0] ctrl_reg;
reg [`TOBS_CTRL_W-1:0] ctrl_next;
reg strap_pend_reg;

always @*
begin
	ctrl_next = ctrl_reg;
	if (ctrl_wr)
	begin
		ctrl_next[`TOBS_CTRL_BIGEND_BIT] = reg_wdata[`TOBS_CTRL_BIGEND_BIT];
		ctrl_next[`TOBS_CTRL_HIVEC_BIT] = reg_wdata[`TOBS_CTRL_HIVEC_BIT];
		ctrl_next[`TOBS_CTRL_GATE_BIT] = reg_wdata[`TOBS_CTRL_GATE_BIT];
	end
	// strap beats a software write on the first edge out of reset
	if (strap_pend_reg)
	begin
		ctrl_next[`TOBS_CTRL_HIVEC_BIT] = vector_strap_in;
	end
end

// ****************************************
// control register
// ****************************************
always @(posedge sys_clk or negedge debug_reset_n)
begin
	if (!debug_reset_n)
	begin
		ctrl_reg <= `TOBS_CTRL_RST;
	end
	else if (sys_rst)
	begin
		ctrl_reg <= `TOBS_CTRL_RST;
	end
	else
	begin
		ctrl_reg <= ctrl_next;
	end
end

// ****************************************
// strap capture
// ****************************************
// pending flag lets the strap be taken on the first edge after either reset
always @(posedge sys_clk or negedge debug_reset_n)
begin
	if (!debug_reset_n)
	begin
		strap_pend_reg <= 1'b1;
	end
	else if (sys_rst)
	begin
		strap_pend_reg <= 1'b1;
	end
	else
	begin
		strap_pend_reg <= 1'b0;
	end
end

// ****************************************
// trace stage load control
// ****************************************
wire gate_hold;
wire stage_load;

// gate only holds the stage when software asked for it
assign gate_hold = ctrl_reg[`TOBS_CTRL_GATE_BIT] & ~trace_port_enable_in;
assign stage_load = bus_clock_enable & ~gate_hold;

// ****************************************
// trace stage inputs
// ****************************************
wire in_isa;
wire [`TOBS_SIZE_W-1:0] in_size;
wire [`TOBS_WORD_W-1:0] in_rdata;
wire [`TOBS_WORD_W-1:0] in_wdata;
wire in_ivalid;
wire in_wnr;
wire [`TOBS_STAGE_W-1:0] stage_d;
wire [`TOBS_STAGE_W-1:0] stage_q;

assign in_isa = core_isa_alt;
assign in_size = core_access_size;
assign in_rdata = core_read_data;
assign in_wdata = core_write_data;
assign in_ivalid = core_exec_valid & ~core_exec_flush;
assign in_wnr = core_write;

// order must match the stage bit positions
assign stage_d = {
	in_isa,
	in_size,
	in_rdata,
	in_wdata,
	in_ivalid,
	in_wnr
};

// ****************************************
// trace stage
// ****************************************
tobs_stage u_stage
(
	.sys_clk(sys_clk),
	.debug_reset_n(debug_reset_n),
	.sys_rst(sys_rst),
	.load(stage_load),
	.d(stage_d),
	.q(stage_q)
);

// ****************************************
// trace outputs
// ****************************************
assign trace_write_not_read = stage_q[`TOBS_STG_WNR_BIT];
assign trace_instr_valid = stage_q[`TOBS_STG_IVALID_BIT];
assign trace_write_data = stage_q[`TOBS_STG_WDATA_HI:`TOBS_STG_WDATA_LO];
assign trace_read_data = stage_q[`TOBS_STG_RDATA_HI:`TOBS_STG_RDATA_LO];
assign trace_access_size = stage_q[`TOBS_STG_SIZE_HI:`TOBS_STG_SIZE_LO];
assign trace_isa_state = stage_q[`TOBS_STG_ISA_BIT];

// ****************************************
// configuration outputs
// ****************************************
// straight from the control flops, not held by the bus enable
assign trace_endian_out = ctrl_reg[`TOBS_CTRL_BIGEND_BIT];
assign endian_out = ctrl_reg[`TOBS_CTRL_BIGEND_BIT];
assign trace_vector_base_high = ctrl_reg[`TOBS_CTRL_HIVEC_BIT];

// ****************************************
// wait indicator
// ****************************************
// follows the core every edge; it only flags a wait, it gates nothing
always @(posedge sys_clk or negedge debug_reset_n)
begin
	if (!debug_reset_n)
	begin
		trace_wait_indicator <= 1'b0;
	end
	else if (sys_rst)
	begin
		trace_wait_indicator <= 1'b0;
	end
	else
	begin
		trace_wait_indicator <= core_wait;
	end
end

// ****************************************
// write-data capture next value
// ****************************************
// snapshot of the last traced write word
reg [`TOBS_WORD_W-1:0] capt_reg;
reg [`TOBS_WORD_W-1:0] capt_next;
wire capt_set;
wire capt_clr;

assign capt_set = stage_load & core_write;
assign capt_clr = capt_wr;

always @*
begin
	capt_next = capt_reg;
	if (capt_clr)
	begin
		capt_next = `TOBS_CAPT_RST;
	end
	// a traced write in the same cycle wins over the clear
	if (capt_set)
	begin
		capt_next = core_write_data;
	end
end

// ****************************************
// write-data capture register
// ****************************************
always @(posedge sys_clk or negedge debug_reset_n)
begin
	if (!debug_reset_n)
	begin
		capt_reg <= `TOBS_CAPT_RST;
	end
	else if (sys_rst)
	begin
		capt_reg <= `TOBS_CAPT_RST;
	end
	else
	begin
		capt_reg <= capt_next;
	end
end

// ****************************************
// status word
// ****************************************
reg [`TOBS_DATA_W-1:0] status_word;

always @*
begin
	status_word = {`TOBS_DATA_W{1'b0}};
	status_word[`TOBS_STAT_ISA_BIT] = trace_isa_state;
	status_word[`TOBS_STAT_PEN_BIT] = trace_port_enable_in;
	status_word[`TOBS_STAT_WAIT_BIT] = trace_wait_indicator;
	status_word[`TOBS_STAT_IVALID_BIT] = trace_instr_valid;
	status_word[`TOBS_STAT_WNR_BIT] = trace_write_not_read;
	status_word[`TOBS_STAT_SIZE_HI:`TOBS_STAT_SIZE_LO] = trace_access_size;
end

// ****************************************
// register read mux
// ****************************************
reg [`TOBS_DATA_W-1:0] rdata_next;

// zero outside a read so the data stand for one cycle only
always @*
begin
	rdata_next = {`TOBS_DATA_W{1'b0}};
	if (reg_read)
	begin
		case (reg_addr)
			`TOBS_CTRL_ADDR:
			begin
				rdata_next[`TOBS_CTRL_W-1:0] = ctrl_reg;
			end
			`TOBS_STATUS_ADDR:
			begin
				rdata_next = status_word;
			end
			`TOBS_CAPT_ADDR:
			begin
				rdata_next = capt_reg;
			end
			default:
			begin
				rdata_next = {`TOBS_DATA_W{1'b0}};
			end
		endcase
	end
end

// ****************************************
// read data register
// ****************************************
always @(posedge sys_clk or negedge debug_reset_n)
begin
	if (!debug_reset_n)
	begin
		reg_rdata <= {`TOBS_DATA_W{1'b0}};
	end
	else if (sys_rst)
	begin
		reg_rdata <= {`TOBS_DATA_W{1'b0}};
	end
	else
	begin
		reg_rdata <= rdata_next;
	end
end

endmodule // tobs_port

// File: hdl/tobs_stage.v
// holding register for the trace outputs with load enable
// assumes debug_reset_n async active low, sys_rst synchronous active high
`timescale 1ns/100ps
`include "tobs_consts.vh"

module tobs_stage
(
	// clock and resets
	input wire sys_clk,
	input wire debug_reset_n,
	input wire sys_rst,
	// data
	input wire load,
	input wire [`TOBS_STAGE_W-1:0] d,
	output reg [`TOBS_STAGE_W-1:0] q
);

// ****************************************
// per-bit holding flops
// ****************************************
genvar gi;
generate
	for (gi = 0; gi < `TOBS_STAGE_W; gi = gi + 1)
	begin : g_bit
		always @(posedge sys_clk or negedge debug_reset_n)
		begin
			if (!debug_reset_n)
				q[gi] <= 1'b0;
			else if (sys_rst)
				q[gi] <= 1'b0;
			else if (load)
				q[gi] <= d[gi];
		end
	end
endgenerate

endmodule // tobs_stage

// File: inc/tobs_consts.vh
// constants for the trace observation port: register map, fields, resets
// assumes inclusion by bare name from every design file that needs them
`ifndef TOBS_CONSTS_VH
`define TOBS_CONSTS_VH

// ****************************************
// register bus
// ****************************************
`define TOBS_ADDR_W 8
`define TOBS_DATA_W 32
`define TOBS_CTRL_ADDR 8'h00
`define TOBS_STATUS_ADDR 8'h04
`define TOBS_CAPT_ADDR 8'h08

// ****************************************
// control register fields
// ****************************************
`define TOBS_CTRL_BIGEND_BIT 0
`define TOBS_CTRL_HIVEC_BIT 1
`define TOBS_CTRL_GATE_BIT 2
`define TOBS_CTRL_W 3
`define TOBS_CTRL_RST 3'h0

// ****************************************
// status register fields
// ****************************************
`define TOBS_STAT_ISA_BIT 0
`define TOBS_STAT_PEN_BIT 1
`define TOBS_STAT_WAIT_BIT 2
`define TOBS_STAT_IVALID_BIT 3
`define TOBS_STAT_WNR_BIT 4
`define TOBS_STAT_SIZE_LO 5
`define TOBS_STAT_SIZE_HI 6

// ****************************************
// trace stage layout
// ****************************************
`define TOBS_SIZE_W 2
`define TOBS_WORD_W 32
`define TOBS_STAGE_W 69
`define TOBS_STAGE_RST 69'h0
`define TOBS_CAPT_RST 32'h0

// ****************************************
// trace stage bit positions
// ****************************************
`define TOBS_STG_WNR_BIT 0
`define TOBS_STG_IVALID_BIT 1
`define TOBS_STG_WDATA_LO 2
`define TOBS_STG_WDATA_HI 33
`define TOBS_STG_RDATA_LO 34
`define TOBS_STG_RDATA_HI 65
`define TOBS_STG_SIZE_LO 66
`define TOBS_STG_SIZE_HI 67
`define TOBS_STG_ISA_BIT 68

`endif
